// *** hw/tcsp_pkg.sv ***
// Constants, states and state records of the tracker configuration serial port.
package tcsp_pkg;

  // Register geometry and command decode.
  localparam int         REG_W     = 56;
  localparam logic [3:0] DATA_N    = 4'h7;
  localparam logic [3:0] BIT_N     = 4'h8;
  localparam logic [7:0] CMD_BASE  = 8'he0;
  localparam logic [2:0] IDX_MEA_A = 3'h0;
  localparam logic [2:0] IDX_MEA_B = 3'h1;
  localparam logic [2:0] IDX_CTRL  = 3'h3;
  localparam logic [2:0] IDX_TRIM  = 3'h4;
  localparam logic [2:0] IDX_THR   = 3'h5;
  localparam logic [2:0] IDX_NONE  = 3'h7;

  // Upper four bits of the 7-bit target address; the straps give the low three.
  localparam logic [3:0] ADDR_HIGH = 4'h0;

  // Only the standard-mode bus rate is supported.
  localparam int BUS_RATE_KHZ = 100;

  // Field positions.
  localparam int TRIM_W        = 8;
  localparam int TRIM_VOUT_LSB = 24;
  localparam int TRIM_IOUT_LSB = 16;
  localparam int TRIM_VIN_LSB  = 8;
  localparam int TRIM_IIN_LSB  = 0;
  localparam int THR_W         = 10;
  localparam int THR_IIN_HI    = 30;
  localparam int THR_IIN_LO    = 20;
  localparam int THR_IOUT_HI   = 10;
  localparam int THR_IOUT_LO   = 0;
  localparam int DUTY_LSB      = 5;
  localparam int DUTY_W        = 9;

  // Reset values.
  localparam logic [55:0] CTRL_RST = {16'h0000, 10'h3ff, 10'h3ff, 3'h3, 3'h3, 9'h0ff, 5'h00};
  localparam logic [55:0] TRIM_RST = 56'h0;
  localparam logic [55:0] THR_RST  = {16'h0, 10'h028, 10'h018, 10'h028, 10'h018};

  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_RX   = 3'b001,
    LS_ACK  = 3'b010,
    LS_TX   = 3'b011,
    LS_RACK = 3'b100
  } tcsp_link_e;

  typedef struct packed {
    logic [2:0]  scl_p;
    logic [2:0]  sda_p;
    logic [2:0]  strap_m;
    logic [2:0]  strap_q;
    tcsp_link_e  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        first;
    logic        rw;
    logic [3:0]  nbyte;
    logic [2:0]  cidx;
    logic [55:0] wbuf;
    logic [55:0] rd;
    logic        wr_tgl;
    logic        sel_tgl;
    logic        sda_oe;
  } tcsp_link_s;

  typedef struct packed {
    logic [2:0]  wr_s;
    logic [2:0]  sel_s;
    logic [55:0] ctrl;
    logic [55:0] trim;
    logic [55:0] thr;
    logic [55:0] snap;
    logic        track;
  } tcsp_core_s;

endpackage : tcsp_pkg

// *** hw/tcsp_serial_port.sv ***
// Serial target port with the offset-trim and current-threshold registers.
//
// Overview of operation
// [R01] Trim register: four 8-bit offsets, reset zero.
// [R02] Threshold register: four 10-bit fields, reset 40/24.
// [R03] Thresholds compare against 10-bit current readings.
// [R04] Comparisons decide tracking entry and exit.
// [R05] Master sets PWM duty through register writes.
// [R06] Three straps form address, first is MSB.
// [R07] High strap reads one, grounded strap zero.
// [R08] Command byte 0xE0 plus index selects register.
// [R09] Measurement registers zero and one are read-only.
// [R10] Registers three, four, five write and read back.
// [R11] Registers are 56 bits, moved as seven bytes.
// [R12] Read returns seven data bytes, frames 5-11.
// [R13] Data bytes go least significant byte first.
// [R14] Master writes its bytes in frames 4-11.
// [R15] Bus runs at 100kHz only.
// [R16] First write byte selects, seven data follow.
// [R17] Acknowledge only own address, else release line.
`timescale 1ns/1ps
`default_nettype none

module tcsp_serial_port (
  // System clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,

  // Link sampling clock.
  input  wire logic        link_clock,

  // Serial bus pins.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,

  // Address straps.
  input  wire logic        address_strap_msb,
  input  wire logic        address_strap_mid,
  input  wire logic        address_strap_lsb,

  // Converter readings.
  input  wire logic [55:0] measurement_reg_a,
  input  wire logic [9:0]  input_current_reading,
  input  wire logic [9:0]  output_current_reading,
  input  wire logic [9:0]  input_voltage_reading,
  input  wire logic [9:0]  output_voltage_reading,

  // Configuration outputs.
  output logic [55:0]      control_override_reg,
  output logic [55:0]      sense_offset_trims,
  output logic [55:0]      current_start_thresholds,
  output logic [8:0]       pwm_duty,
  output logic             tracking_active
);

  // Link-domain state and its next value.
  tcsp_pkg::tcsp_link_s lk;
  tcsp_pkg::tcsp_link_s next_lk;

  // Core-domain state and its next value.
  tcsp_pkg::tcsp_core_s cs;
  tcsp_pkg::tcsp_core_s next_cs;

  // Bus events decoded from the synchronised pins.
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        sda_now;

  // Word returned for the second measurement index.
  logic [55:0] meas_b;

  // Threshold fields taken apart for the tracking comparisons.
  logic [9:0]  iin_hi;
  logic [9:0]  iin_lo;
  logic [9:0]  iout_hi;
  logic [9:0]  iout_lo;

  // Link domain: pins pass two flops, then edges are taken between stage two and three.
  // The bus rate is slow enough that a few link clocks of delay never matter.
  always_comb begin
    next_lk         = lk;

    // Synchronisers for the bus pins and the address straps.
    next_lk.scl_p   = {lk.scl_p[1:0], scl_i}; // see [R15]
    next_lk.sda_p   = {lk.sda_p[1:0], sda_i};
    next_lk.strap_m = {address_strap_msb, address_strap_mid, address_strap_lsb}; // see [R06]
    next_lk.strap_q = lk.strap_m; // see [R07]

    // Edge and condition decode from the settled stages.
    // Only the second flop of each pin and the stage after it are read here.
    sda_now         = lk.sda_p[1];
    scl_rise        = lk.scl_p[1] & ~lk.scl_p[2];
    scl_fall        = ~lk.scl_p[1] & lk.scl_p[2];
    bus_start       = lk.scl_p[1] & lk.scl_p[2] & lk.sda_p[2] & ~sda_now;
    bus_stop        = lk.scl_p[1] & lk.scl_p[2] & ~lk.sda_p[2] & sda_now;

    // A start restarts the byte framer from any state; a stop releases the line.
    if (bus_start) begin
      next_lk.st     = tcsp_pkg::LS_RX;
      next_lk.cnt    = 4'h0;
      next_lk.first  = 1'b1;
      next_lk.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_lk.st     = tcsp_pkg::LS_IDLE;
      next_lk.sda_oe = 1'b0;
    end else begin
      case (lk.st)

        // Shift in on each rising bus clock and answer on the falling edge after bit eight.
        tcsp_pkg::LS_RX: begin
          // Bits are taken high bit first.
          if (scl_rise) begin
            next_lk.sh  = {lk.sh[6:0], sda_now};
            next_lk.cnt = lk.cnt + 4'h1;
          end else if (scl_fall && lk.cnt == tcsp_pkg::BIT_N) begin
            // The first byte after a start carries the address; only a match is acknowledged.
            if (lk.first) begin
              if (lk.sh[7:1] == {tcsp_pkg::ADDR_HIGH, lk.strap_q}) begin // see [R17]
                next_lk.sda_oe = 1'b1;
                next_lk.st     = tcsp_pkg::LS_ACK;
                next_lk.rw     = lk.sh[0];
                next_lk.first  = 1'b0;
                next_lk.nbyte  = 4'h0;
                next_lk.rd     = cs.snap;
              end else begin
                // Another target is addressed, so the line stays released until the next start.
                next_lk.st = tcsp_pkg::LS_IDLE;
              end
            end else begin
              next_lk.sda_oe = 1'b1;
              next_lk.st     = tcsp_pkg::LS_ACK;
              if (lk.nbyte == 4'h0) begin
                // The selected word is copied in the core domain for a later read.
                // A command outside the register window selects nothing.
                if (lk.sh[7:3] == tcsp_pkg::CMD_BASE[7:3]) begin // see [R08]
                  next_lk.cidx = lk.sh[2:0];
                end else begin
                  next_lk.cidx = tcsp_pkg::IDX_NONE;
                end
                next_lk.sel_tgl = ~lk.sel_tgl; // see [R16]
              end else begin
                // Data bytes arrive low byte first, so each new byte enters at the top.
                next_lk.wbuf = {lk.sh, lk.wbuf[55:8]}; // see [R13]
                // Only a complete block of seven bytes is committed.
                if (lk.nbyte == tcsp_pkg::DATA_N) begin
                  next_lk.wr_tgl = ~lk.wr_tgl; // see [R11]
                end
              end

              // The count stops past the seventh data byte, so extra bytes only shift the buffer and commit nothing.
              if (lk.nbyte <= tcsp_pkg::DATA_N) begin
                next_lk.nbyte = lk.nbyte + 4'h1; // see [R14]
              end
            end
          end
        end

        // Acknowledge phase: the line is held low until the next falling bus clock.
        tcsp_pkg::LS_ACK: begin
          if (scl_fall) begin
            // A read starts on the first data bit; a write goes back to shifting in.
            next_lk.cnt = 4'h0;
            if (lk.rw) begin
              next_lk.st     = tcsp_pkg::LS_TX;
              next_lk.sh     = lk.rd[7:0];
              next_lk.sda_oe = ~lk.rd[7];
            end else begin
              next_lk.st     = tcsp_pkg::LS_RX;
              next_lk.sda_oe = 1'b0;
            end
          end
        end

        // Transmit phase: each falling bus clock puts the next bit out, high bit first.
        tcsp_pkg::LS_TX: begin
          if (scl_fall) begin
            if (lk.cnt == 4'h7) begin
              // After the eighth bit the line is released for the master's answer.
              next_lk.sda_oe = 1'b0;
              next_lk.st     = tcsp_pkg::LS_RACK;
              next_lk.rd     = {8'hff, lk.rd[55:8]}; // see [R12]
            end else begin
              next_lk.sh     = {lk.sh[6:0], 1'b1};
              next_lk.sda_oe = ~lk.sh[6];
              next_lk.cnt    = lk.cnt + 4'h1;
            end
          end
        end

        // Master answer phase after each byte sent.
        tcsp_pkg::LS_RACK: begin
          // A high answer from the master ends the read.
          if (scl_rise && sda_now) begin
            next_lk.st = tcsp_pkg::LS_IDLE;
          end else if (scl_fall) begin
            next_lk.st     = tcsp_pkg::LS_TX;
            next_lk.cnt    = 4'h0;
            next_lk.sh     = lk.rd[7:0];
            next_lk.sda_oe = ~lk.rd[7];
          end
        end

        // Idle: the line stays released until a start.
        tcsp_pkg::LS_IDLE: begin
          next_lk.sda_oe = 1'b0;
        end

        // An unknown state falls back to idle with the line released.
        default: begin
          next_lk.st     = tcsp_pkg::LS_IDLE;
          next_lk.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Reset holds the link idle with both pins seen high.
  // This keeps a false start or edge from following the release of reset.
  always_ff @(posedge link_clock or negedge nrst) begin
    if (!nrst) begin
      lk <= '{st: tcsp_pkg::LS_IDLE, scl_p: 3'h7, sda_p: 3'h7, default: '0};
    end else begin
      lk <= next_lk;
    end
  end

  // Core domain: toggles from the link pass two flops; the words they flag are held still meanwhile.

  // Threshold fields are read where they sit in the register.
  assign iin_hi  = cs.thr[tcsp_pkg::THR_IIN_HI +: tcsp_pkg::THR_W];
  assign iin_lo  = cs.thr[tcsp_pkg::THR_IIN_LO +: tcsp_pkg::THR_W];
  assign iout_hi = cs.thr[tcsp_pkg::THR_IOUT_HI +: tcsp_pkg::THR_W];
  assign iout_lo = cs.thr[tcsp_pkg::THR_IOUT_LO +: tcsp_pkg::THR_W];

  // The second measurement word packs the tracking flag above the four readings.
  assign meas_b  = {15'h0, cs.track, output_voltage_reading, output_current_reading,
                    input_voltage_reading, input_current_reading};

  always_comb begin
    next_cs       = cs;

    // Toggles from the link domain pass two flops before they are compared.
    next_cs.wr_s  = {cs.wr_s[1:0], lk.wr_tgl};
    next_cs.sel_s = {cs.sel_s[1:0], lk.sel_tgl};

    // A write toggle commits the gathered word; read-only indexes drop it.
    if (cs.wr_s[2] ^ cs.wr_s[1]) begin
      case (lk.cidx)
        tcsp_pkg::IDX_CTRL: next_cs.ctrl = lk.wbuf; // see [R10]
        tcsp_pkg::IDX_TRIM: next_cs.trim = lk.wbuf; // see [R01]
        tcsp_pkg::IDX_THR:  next_cs.thr  = lk.wbuf; // see [R02]
        default: ; // see [R09]
      endcase
    end

    // A select toggle freezes the chosen word for the read that follows.
    if (cs.sel_s[2] ^ cs.sel_s[1]) begin
      case (lk.cidx)
        tcsp_pkg::IDX_MEA_A: next_cs.snap = measurement_reg_a;
        tcsp_pkg::IDX_MEA_B: next_cs.snap = meas_b;
        tcsp_pkg::IDX_CTRL:  next_cs.snap = cs.ctrl;
        tcsp_pkg::IDX_TRIM:  next_cs.snap = cs.trim;
        tcsp_pkg::IDX_THR:   next_cs.snap = cs.thr;
        default:             next_cs.snap = 56'h0;
      endcase
    end

    // Hysteresis: both currents at or above their high marks start, either below its low mark stops.
    if (!cs.track) begin
      next_cs.track = (input_current_reading >= iin_hi) && (output_current_reading >= iout_hi); // see [R03] [R04]
    end else begin
      next_cs.track = !((input_current_reading < iin_lo) || (output_current_reading < iout_lo)); // see [R04]
    end
  end

  // Registers return to their reset values and tracking starts off.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs <= '{ctrl: tcsp_pkg::CTRL_RST, trim: tcsp_pkg::TRIM_RST, thr: tcsp_pkg::THR_RST, default: '0};
    end else begin
      cs <= next_cs;
    end
  end

  // The data pin is open drain, so only its enable ever changes.
  assign sda_o                    = 1'b0;
  assign sda_oe                   = lk.sda_oe;

  // Register outputs and the fields taken from them.
  // Every one of them comes straight from a register.
  assign control_override_reg     = cs.ctrl;
  assign sense_offset_trims       = cs.trim;
  assign current_start_thresholds = cs.thr;
  assign pwm_duty                 = cs.ctrl[tcsp_pkg::DUTY_LSB +: tcsp_pkg::DUTY_W]; // see [R05]
  assign tracking_active          = cs.track;

endmodule : tcsp_serial_port

`default_nettype wire

// *** dv/tcsp_monitor.sv ***
// Checker of the serial port's registers, tracking state and data line.
`timescale 1ns/1ps
`default_nettype none
module tcsp_monitor (
  // Clocks, reset and bus pins.
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        link_clock,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Readings and registers.
  input wire logic [9:0]  input_current_reading,
  input wire logic [9:0]  output_current_reading,
  input wire logic [55:0] control_override_reg,
  input wire logic [55:0] sense_offset_trims,
  input wire logic [55:0] current_start_thresholds,
  input wire logic [8:0]  pwm_duty,
  input wire logic        tracking_active
);
  wire logic [55:0] thr = current_start_thresholds;
  wire logic [9:0]  ii  = input_current_reading;
  wire logic [9:0]  io  = output_current_reading;
  sequence s_leave;
    ii < thr[29:20] || io < thr[9:0];
  endsequence
  sequence s_enter;
    ii >= thr[39:30] && io >= thr[19:10] && ii >= thr[29:20] && io >= thr[9:0];
  endsequence
  property p_on; @(posedge clock) disable iff (!nrst) s_enter |=> tracking_active; endproperty
  a_on: assert property (p_on) else $error("tracking not entered");
  property p_off; @(posedge clock) disable iff (!nrst) s_leave |=> !tracking_active; endproperty
  a_off: assert property (p_off) else $error("tracking not left");
  property p_duty; @(posedge clock) disable iff (!nrst) pwm_duty == control_override_reg[13:5]; endproperty
  a_duty: assert property (p_duty) else $error("duty differs from field");
  property p_rst; @(posedge clock) disable iff (!nrst) $rose(nrst) |-> sense_offset_trims == 56'h0
    && thr == tcsp_pkg::THR_RST; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_trim; @(posedge clock) disable iff (!nrst) $changed(sense_offset_trims) |-> $stable(thr)
    && $stable(control_override_reg); endproperty
  a_trim: assert property (p_trim) else $error("two registers changed");
  property p_thr; @(posedge clock) disable iff (!nrst) $changed(thr) |-> $stable(sense_offset_trims); endproperty
  a_thr: assert property (p_thr) else $error("two registers changed");
  property p_sdao; @(posedge link_clock) disable iff (!nrst) sda_oe |-> sda_o == 1'b0; endproperty
  a_sdao: assert property (p_sdao) else $error("data line driven high");
  property p_oe; @(posedge link_clock) disable iff (!nrst) $rose(sda_oe) |-> !scl_i; endproperty
  a_oe: assert property (p_oe) else $error("data changed with clock high");
endmodule : tcsp_monitor
bind tcsp_serial_port tcsp_monitor u_mon (.clock(clock), .nrst(nrst), .link_clock(link_clock),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .input_current_reading(input_current_reading),
  .output_current_reading(output_current_reading), .control_override_reg(control_override_reg),
  .sense_offset_trims(sense_offset_trims), .current_start_thresholds(current_start_thresholds),
  .pwm_duty(pwm_duty), .tracking_active(tracking_active));
`default_nettype wire

// *** dv/tcsp_bus_master.sv ***
// Serial bus master model driving the clock and pulling the data line low.
`timescale 1ns/1ps
`default_nettype none
module tcsp_bus_master #(parameter int Q = 2500) (
  // Bus pins.
  output logic     scl,
  output logic     pull,
  input wire logic sda
);
  logic [7:0] rx;
  logic       ak;
  logic [3:0] nacks;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Four quarters make one 10 us bit; data moves only mid-low.
  task automatic bit_io(input logic b, output logic got);
    #Q pull = ~b;
    #Q scl = 1'b1;
    got = sda;
    #(2*Q) scl = 1'b0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] tx, input logic nine);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(nine, ak);
    nacks = nacks + {3'h0, ak};
  endtask : byte_io
  // A one makes a start condition, a zero a stop condition.
  task automatic cond(input logic s);
    #Q pull = ~s;
    #Q scl = 1'b1;
    #(2*Q) pull = s;
    #(2*Q) scl = ~s;
  endtask : cond
  task automatic head(input logic [6:0] a, input logic [7:0] c);
    nacks = 4'h0;
    cond(1'b1);
    byte_io({a, 1'b0}, 1'b1);
    byte_io(c, 1'b1);
  endtask : head
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [55:0] d);
    head(a, c);
    for (int k = 0; k < 7; k++) byte_io(d[8*k+:8], 1'b1);
    cond(1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [55:0] d);
    head(a, c);
    cond(1'b1);
    byte_io({a, 1'b1}, 1'b1);
    for (int k = 0; k < 7; k++) begin
      byte_io(8'hff, k == 6);
      d[8*k+:8] = rx;
    end
    cond(1'b0);
  endtask : rd
endmodule : tcsp_bus_master
`default_nettype wire

// *** dv/tcsp_serial_port_test.sv ***
// Self-checking bench of the tracker configuration serial port.
`timescale 1ns/1ps
`default_nettype none
module tcsp_serial_port_test;
  logic        clock = 1'b0;
  logic        link_clock = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  straps = 3'h1;
  logic [2:0]  adr [3] = '{3'h1, 3'h4, 3'h7};
  logic [55:0] mea = 56'h0;
  logic [9:0]  ii = 10'h0;
  logic [9:0]  io = 10'h0;
  logic [9:0]  vv = 10'h0;
  logic [55:0] ctrl, trim, thr, tv, hv, v, got;
  logic        sda_o, sda_oe, trk, xt, scl, pull;
  logic [8:0]  duty;
  wire logic   sda = ~((sda_oe & ~sda_o) | pull);
  int          fail_count = 0;
  int          checks_done = 0;
  int          seed = 32'h58fd;
  always #12.5 clock = ~clock;
  initial #1.7 forever #3 link_clock = ~link_clock;
  tcsp_serial_port DUT (.clock(clock), .nrst(nrst), .link_clock(link_clock), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .address_strap_msb(straps[2]), .address_strap_mid(straps[1]),
    .address_strap_lsb(straps[0]), .measurement_reg_a(mea), .input_current_reading(ii),
    .output_current_reading(io), .input_voltage_reading(vv), .output_voltage_reading(vv),
    .control_override_reg(ctrl), .sense_offset_trims(trim), .current_start_thresholds(thr),
    .pwm_duty(duty), .tracking_active(trk));
  tcsp_bus_master m (.scl(scl), .pull(pull), .sda(sda));
  task automatic check(input logic [55:0] seen, input logic [55:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic f_trk(input logic p, input logic [9:0] a, input logic [9:0] b,
    input logic [55:0] t);
    if (a < t[29:20] || b < t[9:0]) return 1'b0;
    if (a >= t[39:30] && b >= t[19:10]) return 1'b1;
    return p;
  endfunction : f_trk
  function automatic logic [55:0] rnd();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[55:0];
  endfunction : rnd
  task automatic probe(input logic [6:0] a, input logic want);
    m.cond(1'b1);
    m.byte_io({a, 1'b0}, 1'b1);
    check(56'(m.ak), 56'(want));
    m.cond(1'b0);
  endtask : probe
  task automatic wr_chk(input logic [7:0] c, input logic [55:0] d);
    m.wr(7'h07, c, d);
    repeat (8) @(posedge clock);
    check(56'(m.nacks), 56'h0);
  endtask : wr_chk
  initial begin
    #9_000_000;
    $display("run timed out");
    fail_count++;
    tally_and_finish();
  end
  initial begin
    foreach (adr[j]) begin
      @(posedge clock) straps <= adr[j];
      nrst <= 1'b0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      probe({4'h0, adr[j]}, 1'b0);
    end
    probe(7'h06, 1'b1);
    check(trim, 56'h0);
    check(thr, tcsp_pkg::THR_RST);
    $display("address and reset test done");
    tv = rnd();
    wr_chk(8'he4, tv);
    check(trim, tv);
    m.rd(7'h07, 8'he4, got);
    check(got, tv);
    check(56'(m.nacks), 56'h1);
    hv = rnd();
    hv[39:30] |= 10'h200;
    hv[19:10] |= 10'h200;
    hv[29:20] &= 10'h1ff;
    hv[9:0] &= 10'h1ff;
    wr_chk(8'he5, hv);
    check(thr, hv);
    check(trim, tv);
    $display("register test done");
    xt = 1'b0;
    for (int n = 0; n < 32; n++) begin
      @(posedge clock);
      ii <= $random(seed) & 1 ? hv[39:30] : hv[29:20] - 10'h1;
      io <= $random(seed) & 1 ? hv[19:10] : hv[9:0] - 10'h1;
      vv <= 10'($random(seed));
      repeat (2) @(posedge clock);
      xt = f_trk(xt, ii, io, hv);
      check(56'(trk), 56'(xt));
    end
    v = rnd();
    wr_chk(8'he3, v);
    check(ctrl, v);
    check(56'(duty), 56'(v[13:5]));
    @(posedge clock) mea <= rnd();
    wr_chk(8'he0, rnd());
    m.rd(7'h07, 8'he0, got);
    check(got, mea);
    $display("control and read-only test done");
    tally_and_finish();
  end
endmodule : tcsp_serial_port_test
`default_nettype wire
